// ---- src/mid_defs.svh ----
`ifndef MID_DEFS_SVH
`define MID_DEFS_SVH
`define MID_WORD_W 14
`define MID_PTR_W 12
`define MID_FADDR_W 7
`define MID_FILE_DEPTH 128
`define MID_STACK_DEPTH 8
`define MID_CLS_BYTE 2'h0
`define MID_CLS_BIT 2'h1
`define MID_CLS_CALL 2'h2
`define MID_CLS_JUMP 2'h3
`define MID_OP_MISC 4'h0
`define MID_OP_CLR 4'h1
`define MID_OP_SUB 4'h2
`define MID_OP_DEC 4'h3
`define MID_OP_OR 4'h4
`define MID_OP_AND 4'h5
`define MID_OP_XOR 4'h6
`define MID_OP_ADD 4'h7
`define MID_OP_MOVE 4'h8
`define MID_OP_COM 4'h9
`define MID_OP_INC 4'hA
`define MID_OP_DECSZ 4'hB
`define MID_OP_RR 4'hC
`define MID_OP_RL 4'hD
`define MID_OP_SWAP 4'hE
`define MID_OP_INCSZ 4'hF
`define MID_LIT_EXIT 4'h8
`define MID_LIT_LOAD 4'h9
`define MID_LIT_OR 4'hA
`define MID_LIT_AND 4'hB
`define MID_LIT_ADD 4'hC
`define MID_LIT_XOR 4'hF
`define MID_W_KICK 14'h0004
`define MID_W_SLEEP 14'h0003
`define MID_W_RET 14'h0040
`define MID_W_RETI 14'h0060
`define MID_W_CLRW 14'h0140
`define MID_PTR_RST 12'h000
`define MID_ACC_RST 8'h00
`define MID_WORD_RST 14'h0000
`endif

// ---- src/mid_pkg.sv ----
package mid_pkg;
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_STANDBY = 2'b10
    } mid_state_t;
    typedef enum logic [3:0] {
        ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_COM, ALU_DEC,
        ALU_INC, ALU_SWAP, ALU_RL, ALU_RR, ALU_PASS, ALU_CLR
    } mid_alu_op_t;
    typedef struct packed {
        logic carry;
        logic half_carry_flag;
        logic zero;
        logic watchdog_expired_flag;
        logic sleep_entered_flag;
    } mid_status_t;
endpackage

// ---- src/mid_alu.sv ----
`timescale 1ns/100ps
module mid_alu (
    // Operation
    input mid_pkg::mid_alu_op_t op,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic c_in,
    // Result
    output logic [7:0] res,
    output logic c_out,
    output logic dc_out,
    output logic z_out
);
    import mid_pkg::*;
    always_comb begin
        res = 8'h00;
        c_out = c_in;
        dc_out = 1'b0;
        case (op)
            ALU_ADD: begin
                {c_out, res} = {1'b0, a} + {1'b0, b};
                dc_out = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
            end
            ALU_SUB: begin
                res = b - a;
                c_out = (b >= a);
                dc_out = (b[3:0] >= a[3:0]);
            end
            ALU_AND: res = a & b;
            ALU_OR: res = a | b;
            ALU_XOR: res = a ^ b;
            ALU_COM: res = ~b;
            ALU_DEC: res = b - 8'h01;
            ALU_INC: res = b + 8'h01;
            ALU_SWAP: res = {b[3:0], b[7:4]};
            ALU_RL: begin
                res = {b[6:0], c_in};
                c_out = b[7];
            end
            ALU_RR: begin
                res = {c_in, b[7:1]};
                c_out = b[0];
            end
            ALU_PASS: res = b;
            ALU_CLR: res = 8'h00;
            default: res = 8'h00;
        endcase
        z_out = (res == 8'h00);
    end
endmodule

// ---- src/mid_core.sv ----
`timescale 1ns/100ps
`include "mid_defs.svh"
module mid_core #(
    parameter int FILE_DEPTH = `MID_FILE_DEPTH,
    parameter int STACK_DEPTH = `MID_STACK_DEPTH
) (
    // Clock and reset
    input logic core_clk,
    input logic sys_rst,
    // Program memory
    input logic [`MID_WORD_W-1:0] instr_word,
    output logic [`MID_PTR_W-1:0] fetch_pointer,
    // Control
    input logic wake_req,
    input logic wdt_expire,
    // Core state
    output logic [7:0] accum,
    output mid_pkg::mid_status_t status,
    output logic [`MID_PTR_W-1:0] stack_head,
    output logic standby,
    output logic wdt_restart,
    // File write monitor
    output logic file_we,
    output logic [`MID_FADDR_W-1:0] file_addr,
    output logic [7:0] file_wdata
);
    import mid_pkg::*;
    localparam int SP_W = $clog2(STACK_DEPTH);

    mid_state_t state, next_state;
    logic [`MID_WORD_W-1:0] exec_word, next_exec_word;
    logic exec_valid, next_exec_valid;
    logic [`MID_PTR_W-1:0] next_fetch_pointer, next_stack_head;
    logic [7:0] next_accum, next_file_wdata;
    mid_status_t next_status;
    logic next_standby, next_wdt_restart, next_file_we;
    logic [`MID_FADDR_W-1:0] next_file_addr;
    logic [SP_W-1:0] sp, next_sp;
    logic [7:0] file_mem [0:FILE_DEPTH-1];
    logic [`MID_PTR_W-1:0] stack_mem [0:STACK_DEPTH-1];

    // Field split of the executing word
    logic go;
    logic [1:0] cls;
    logic [3:0] sub_op;
    logic [`MID_FADDR_W-1:0] op_addr;
    logic [7:0] lit, file_rd;
    logic [`MID_PTR_W-1:0] target;
    logic [2:0] bit_sel;
    assign go = exec_valid && (state == ST_RUN);
    assign cls = exec_word[13:12];
    assign sub_op = exec_word[11:8];
    assign lit = exec_word[7:0];
    assign target = exec_word[11:0];
    assign bit_sel = exec_word[8:6];
    assign op_addr = (cls == `MID_CLS_BIT) ? {1'b0, exec_word[5:0]} : exec_word[6:0];
    assign file_rd = file_mem[op_addr];

    // Decoded controls
    mid_alu_op_t alu_op;
    logic [7:0] alu_b, bit_val, alu_res;
    logic alu_c, alu_dc, alu_z;
    logic wr_w, wr_f, upd_c, upd_dc, upd_z, skip_zero, bit_skip, bit_wr;
    logic jmp, push, pop, kick, sleep_op, is_rot, is_load, is_bit, is_skipop;

    always_comb begin
        alu_op = ALU_PASS;
        alu_b = file_rd;
        bit_val = file_rd;
        {wr_w, wr_f, upd_c, upd_dc, upd_z, skip_zero, bit_skip, bit_wr} = 8'h00;
        {jmp, push, pop, kick, sleep_op, is_rot, is_load, is_bit, is_skipop} = 9'h000;
        case (cls)
            `MID_CLS_BYTE: begin
                wr_w = !exec_word[7];
                wr_f = exec_word[7];
                case (sub_op)
                    `MID_OP_ADD: begin alu_op = ALU_ADD; {upd_c, upd_dc, upd_z} = 3'h7; end
                    `MID_OP_SUB: begin alu_op = ALU_SUB; {upd_c, upd_dc, upd_z} = 3'h7; end
                    `MID_OP_AND: begin alu_op = ALU_AND; upd_z = 1'b1; end
                    `MID_OP_OR: begin alu_op = ALU_OR; upd_z = 1'b1; end
                    `MID_OP_XOR: begin alu_op = ALU_XOR; upd_z = 1'b1; end
                    `MID_OP_COM: begin alu_op = ALU_COM; upd_z = 1'b1; end
                    `MID_OP_DEC: begin alu_op = ALU_DEC; upd_z = 1'b1; end
                    `MID_OP_INC: begin alu_op = ALU_INC; upd_z = 1'b1; end
                    `MID_OP_SWAP: alu_op = ALU_SWAP;
                    `MID_OP_RL: begin alu_op = ALU_RL; upd_c = 1'b1; is_rot = 1'b1; end
                    `MID_OP_RR: begin alu_op = ALU_RR; upd_c = 1'b1; is_rot = 1'b1; end
                    `MID_OP_INCSZ: begin alu_op = ALU_INC; skip_zero = 1'b1; is_skipop = 1'b1; end
                    `MID_OP_DECSZ: begin alu_op = ALU_DEC; skip_zero = 1'b1; is_skipop = 1'b1; end
                    `MID_OP_MOVE: begin
                        upd_z = exec_word[7];
                        wr_f = 1'b0;
                        wr_w = !exec_word[7];
                    end
                    `MID_OP_CLR: begin
                        alu_op = ALU_CLR;
                        upd_z = exec_word[7] || (exec_word == `MID_W_CLRW);
                        wr_w = (exec_word == `MID_W_CLRW);
                    end
                    `MID_OP_MISC: begin
                        alu_b = accum;
                        wr_w = 1'b0;
                        kick = (exec_word == `MID_W_KICK);
                        sleep_op = (exec_word == `MID_W_SLEEP);
                        pop = (exec_word == `MID_W_RET) || (exec_word == `MID_W_RETI);
                        jmp = pop;
                    end
                    default: begin
                        wr_w = 1'b0;
                        wr_f = 1'b0;
                    end
                endcase
            end
            `MID_CLS_BIT: begin
                alu_b = lit;
                if (!exec_word[11]) begin
                    is_bit = 1'b1;
                    bit_wr = !exec_word[10];
                    bit_val[bit_sel] = exec_word[9];
                    bit_skip = exec_word[10] && (file_rd[bit_sel] == exec_word[9]);
                end else begin
                    case (sub_op)
                        `MID_LIT_ADD: begin alu_op = ALU_ADD; wr_w = 1'b1; {upd_c, upd_dc, upd_z} = 3'h7; end
                        `MID_LIT_AND: begin alu_op = ALU_AND; wr_w = 1'b1; upd_z = 1'b1; end
                        `MID_LIT_OR: begin alu_op = ALU_OR; wr_w = 1'b1; upd_z = 1'b1; end
                        `MID_LIT_XOR: begin alu_op = ALU_XOR; wr_w = 1'b1; upd_z = 1'b1; end
                        `MID_LIT_LOAD: begin wr_w = 1'b1; is_load = 1'b1; end
                        `MID_LIT_EXIT: begin wr_w = 1'b1; pop = 1'b1; jmp = 1'b1; end
                        default: wr_w = 1'b0;
                    endcase
                end
            end
            `MID_CLS_CALL: begin push = 1'b1; jmp = 1'b1; end
            `MID_CLS_JUMP: jmp = 1'b1;
            default: jmp = 1'b0;
        endcase
    end

    mid_alu u_alu (
        .op(alu_op),
        .a(accum),
        .b(alu_b),
        .c_in(status.carry),
        .res(alu_res),
        .c_out(alu_c),
        .dc_out(alu_dc),
        .z_out(alu_z)
    );

    logic skip_taken, flush, mem_we;
    logic [7:0] mem_data;
    assign skip_taken = go && ((skip_zero && alu_z) || bit_skip);
    assign flush = skip_taken || (go && jmp);
    assign mem_we = go && (wr_f || bit_wr);
    assign mem_data = bit_wr ? bit_val : alu_res;

    always_comb begin
        next_state = state;
        next_exec_word = exec_word;
        next_exec_valid = exec_valid;
        next_fetch_pointer = fetch_pointer;
        next_stack_head = stack_head;
        next_sp = sp;
        next_accum = accum;
        next_status = status;
        next_wdt_restart = 1'b0;
        next_file_we = mem_we;
        next_file_addr = op_addr;
        next_file_wdata = mem_data;
        case (state)
            ST_RUN: begin
                next_exec_word = instr_word;
                next_exec_valid = !flush;
                next_fetch_pointer = fetch_pointer + `MID_PTR_W'(1);
                if (go && jmp) begin
                    next_fetch_pointer = pop ? stack_head : target;
                end
                if (go && push) begin
                    next_stack_head = fetch_pointer;
                    next_sp = sp + SP_W'(1);
                end
                if (go && pop) begin
                    next_stack_head = stack_mem[sp - SP_W'(1)];
                    next_sp = sp - SP_W'(1);
                end
                if (go && wr_w) begin
                    next_accum = alu_res;
                end
                if (go && upd_c) begin
                    next_status.carry = alu_c;
                end
                if (go && upd_dc) begin
                    next_status.half_carry_flag = alu_dc;
                end
                if (go && upd_z) begin
                    next_status.zero = alu_z;
                end
                if (go && kick) begin
                    next_wdt_restart = 1'b1;
                    next_status.watchdog_expired_flag = 1'b0;
                    next_status.sleep_entered_flag = 1'b0;
                end
                if (go && sleep_op) begin
                    next_state = ST_STANDBY;
                    next_status.watchdog_expired_flag = 1'b0;
                    next_status.sleep_entered_flag = 1'b1;
                end
            end
            ST_STANDBY: begin
                if (wake_req || wdt_expire) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
        if (wdt_expire) begin
            next_status.watchdog_expired_flag = 1'b1;
        end
        next_standby = (next_state == ST_STANDBY);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_RUN;
            exec_word <= `MID_WORD_RST;
            exec_valid <= 1'b0;
            fetch_pointer <= `MID_PTR_RST;
            stack_head <= `MID_PTR_RST;
            sp <= '0;
            accum <= `MID_ACC_RST;
            status <= '0;
            standby <= 1'b0;
            wdt_restart <= 1'b0;
            file_we <= 1'b0;
            file_addr <= '0;
            file_wdata <= 8'h00;
        end else begin
            state <= next_state;
            exec_word <= next_exec_word;
            exec_valid <= next_exec_valid;
            fetch_pointer <= next_fetch_pointer;
            stack_head <= next_stack_head;
            sp <= next_sp;
            accum <= next_accum;
            status <= next_status;
            standby <= next_standby;
            wdt_restart <= next_wdt_restart;
            file_we <= next_file_we;
            file_addr <= next_file_addr;
            file_wdata <= next_file_wdata;
        end
    end

    // Register file and return stack storage
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            file_mem[op_addr] <= mem_data;
        end
        if (go && push) begin
            stack_mem[sp] <= stack_head;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence jump_seq;
        go && jmp && !pop;
    endsequence
    sequence skip_seq;
        skip_taken;
    endsequence

    skip_idle_a: assert property (skip_seq |=> !exec_valid ##1 exec_valid)
        else $error("skipped word was executed");
    jump_target_a: assert property (jump_seq |=> fetch_pointer == $past(target))
        else $error("jump target not loaded");
    call_push_a: assert property (go && push |=> stack_head == $past(fetch_pointer))
        else $error("call return address not stacked");
    rotate_flags_a: assert property (go && is_rot |=> $stable(status.zero) && $stable(status.half_carry_flag))
        else $error("rotate changed other flags");
    skip_flags_a: assert property (go && (is_skipop || is_bit) |=> $stable(status.carry) && $stable(status.zero))
        else $error("skip or bit op changed flags");
    wdt_kick_a: assert property (go && kick |=> wdt_restart && !status.sleep_entered_flag)
        else $error("watchdog kick not applied");
    standby_entry_a: assert property (go && sleep_op |=> standby && status.sleep_entered_flag [*1] ##1 (standby || $past(wake_req) || $past(wdt_expire)))
        else $error("standby not entered");
    load_literal_a: assert property (go && is_load |=> accum == $past(lit) && $stable(status.zero) && $stable(status.carry))
        else $error("literal load wrong");
    dest_accum_a: assert property (go && cls == `MID_CLS_BYTE && !exec_word[7] |=> !file_we)
        else $error("target bit 0 wrote the file");
    // Tested bit and the level that makes it skip
    logic bit_now, test_set;
    assign bit_now = file_rd[bit_sel];
    assign test_set = exec_word[9];

    bit_test_a: assert property (go && is_bit && exec_word[10] |=> exec_valid == ($past(bit_now) != $past(test_set)))
        else $error("bit test skip wrong");
endmodule

// ---- dv/mid_prog_mem.sv ----
`timescale 1ns/100ps
`include "mid_defs.svh"
module mid_prog_mem (
    // Fetch address
    input wire logic [`MID_PTR_W-1:0] fetch_pointer,
    // Word returned
    output logic [`MID_WORD_W-1:0] instr_word
);
    logic [`MID_WORD_W-1:0] mem [0:4095];
    // Whole word read at once, no wait state
    assign instr_word = mem[fetch_pointer];
endmodule

// ---- dv/mcu_instruction_decoder_tb_top.sv ----
`timescale 1ns/100ps
`include "mid_defs.svh"
module mcu_instruction_decoder_tb_top;
    import mid_pkg::*;
    logic core_clk, sys_rst, wake_req, wdt_expire, standby, wdt_restart, file_we;
    logic [13:0] instr_word;
    logic [11:0] fetch_pointer, stack_head;
    logic [7:0] accum, file_wdata, last_data, a, b, k, r;
    logic [6:0] file_addr, last_addr, f;
    logic [10:0] e;
    logic [3:0] op;
    logic [2:0] bi;
    logic d, skip;
    mid_status_t status;
    int errors, tests_run, kicks, j;
    logic [31:0] seed;
    logic [3:0] lops [5] = '{`MID_LIT_ADD, `MID_LIT_AND, `MID_LIT_OR, `MID_LIT_XOR, `MID_LIT_LOAD};
    logic [3:0] lmap [5] = '{`MID_OP_ADD, `MID_OP_AND, `MID_OP_OR, `MID_OP_XOR, `MID_OP_MOVE};
    logic [3:0] bops [11] = '{`MID_OP_ADD, `MID_OP_SUB, `MID_OP_AND, `MID_OP_OR, `MID_OP_XOR,
        `MID_OP_COM, `MID_OP_DEC, `MID_OP_INC, `MID_OP_SWAP, `MID_OP_RL, `MID_OP_RR};

    mid_core mid_core_i (.core_clk(core_clk), .sys_rst(sys_rst), .instr_word(instr_word),
        .fetch_pointer(fetch_pointer), .wake_req(wake_req), .wdt_expire(wdt_expire),
        .accum(accum), .status(status), .stack_head(stack_head), .standby(standby),
        .wdt_restart(wdt_restart), .file_we(file_we), .file_addr(file_addr),
        .file_wdata(file_wdata));
    mid_prog_mem mid_prog_mem_i (.fetch_pointer(fetch_pointer), .instr_word(instr_word));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Last file write and watchdog restart pulses
    always @(negedge core_clk) begin
        if (file_we === 1'b1) begin
            last_addr = file_addr;
            last_data = file_wdata;
        end
        if (wdt_restart === 1'b1) begin
            kicks++;
        end
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Result, carry, half carry, zero with all flags starting at 0
    function automatic logic [10:0] byte_exp(logic [3:0] o, logic [7:0] x, logic [7:0] y);
        logic [7:0] q;
        logic c;
        logic dc;
        logic zf;
        c = 1'b0;
        dc = 1'b0;
        zf = 1'b1;
        q = y;
        case (o)
            `MID_OP_ADD: begin
                {c, q} = {1'b0, y} + {1'b0, x};
                dc = ({1'b0, y[3:0]} + {1'b0, x[3:0]}) > 5'h0F;
            end
            `MID_OP_SUB: begin
                q = y - x;
                c = y >= x;
                dc = y[3:0] >= x[3:0];
            end
            `MID_OP_AND: q = y & x;
            `MID_OP_OR: q = y | x;
            `MID_OP_XOR: q = y ^ x;
            `MID_OP_COM: q = ~y;
            `MID_OP_DEC: q = y - 8'h01;
            `MID_OP_INC: q = y + 8'h01;
            `MID_OP_SWAP: q = {y[3:0], y[7:4]};
            `MID_OP_RL: begin
                q = {y[6:0], 1'b0};
                c = y[7];
            end
            `MID_OP_RR: begin
                q = {1'b0, y[7:1]};
                c = y[0];
            end
            default: zf = 1'b0;
        endcase
        if (o == `MID_OP_SWAP || o == `MID_OP_RL || o == `MID_OP_RR) begin
            zf = 1'b0;
        end
        return {q, c, dc, zf & (q == 8'h00)};
    endfunction

    task chk(input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task put(input int adr, input logic [13:0] w);
        mid_prog_mem_i.mem[adr] = w;
    endtask

    // Fresh program: every word a no-op
    task clr();
        for (int i = 0; i < 4096; i++) begin
            put(i, `MID_WORD_RST);
        end
    endtask

    task start();
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        kicks = 0;
    endtask

    task end_of_test();
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        errors++;
        end_of_test();
    end

    initial begin
        seed = 32'd9398;
        errors = 0;
        tests_run = 0;
        kicks = 0;
        sys_rst = 1'b1;
        wake_req = 1'b0;
        wdt_expire = 1'b0;
        clr();
        step(20);
        // Literal operations, first pass at the carry corner
        for (int i = 0; i < 10; i++) begin
            j = i % 5;
            a = (i < 5) ? 8'hFF : rnd();
            k = (i < 5) ? 8'h01 : rnd();
            put(0, {2'b01, `MID_LIT_LOAD, a});
            put(1, {2'b01, lops[j], k});
            put(2, {2'b11, 12'h002});
            start();
            step(6);
            e = (j == 4) ? {k, 3'b000} : byte_exp(lmap[j], a, k);
            chk(accum, e[10:3]);
            chk(status, {e[2:0], 2'b00});
        end
        // Byte operations to both targets
        for (int i = 0; i < 22; i++) begin
            op = bops[i % 11];
            d = (i >= 11);
            a = rnd();
            b = (i < 11) ? 8'h00 : rnd();
            k = rnd();
            f = k[6:0];
            e = byte_exp(op, a, b);
            put(0, {2'b01, `MID_LIT_LOAD, b});
            put(1, {7'h01, f});
            put(2, {2'b01, `MID_LIT_LOAD, a});
            put(3, {2'b00, op, d, f});
            put(4, {2'b11, 12'h004});
            start();
            step(8);
            chk(accum, d ? a : e[10:3]);
            chk({last_addr, last_data}, {f, d ? e[10:3] : b});
            chk(status, {e[2:0], 2'b00});
        end
        // Skips and bit operations
        for (int i = 0; i < 12; i++) begin
            j = i % 6;
            b = (i < 6) ? ((j == 0) ? 8'hFF : 8'h01) : rnd();
            k = rnd();
            bi = k[2:0];
            k = rnd();
            f = {1'b0, k[5:0]};
            r = (j == 0) ? b + 8'h01 : (j == 1) ? b - 8'h01 : b;
            r = (j == 2) ? b & ~(8'h01 << bi) : (j == 3) ? b | (8'h01 << bi) : r;
            skip = (j < 2) ? (r == 8'h00) : (j == 4) ? !b[bi] : (j == 5) ? b[bi] : 1'b0;
            put(0, {2'b01, `MID_LIT_LOAD, b});
            put(1, {7'h01, f});
            if (j < 2) begin
                put(2, {2'b00, (j == 0) ? `MID_OP_INCSZ : `MID_OP_DECSZ, 1'b1, f});
            end else begin
                put(2, {2'b01, 1'b0, 2'(j - 2), bi, f[5:0]});
            end
            put(3, {2'b01, `MID_LIT_XOR, 8'hFF});
            put(4, {2'b11, 12'h004});
            start();
            step(8);
            chk(accum, skip ? b : 8'(~b));
            chk(last_data, r);
            chk(status, {2'b00, !skip && (b == 8'hFF), 2'b00});
        end
        // Jump, call and exit with literal
        k = rnd();
        clr();
        put(0, {2'b11, 12'h008});
        put(1, `MID_W_KICK);
        put(8, {2'b10, 12'h00C});
        put(9, {2'b01, `MID_LIT_ADD, 8'h01});
        put(10, {2'b11, 12'h00A});
        put(12, {2'b01, `MID_LIT_EXIT, k});
        put(13, `MID_W_KICK);
        start();
        step(1);
        chk(fetch_pointer, 12'h001);
        step(1);
        chk(fetch_pointer, 12'h008);
        step(1);
        chk(fetch_pointer, 12'h009);
        step(1);
        chk({fetch_pointer, stack_head}, {12'h00C, 12'h009});
        step(7);
        chk(accum, 8'(k + 8'h01));
        chk(20'(kicks), 20'h00000);
        // Watchdog expiry, standby, wake and kick
        clr();
        put(2, `MID_W_SLEEP);
        put(3, {2'b01, `MID_LIT_LOAD, 8'h77});
        put(4, `MID_W_KICK);
        put(5, {2'b11, 12'h005});
        start();
        wdt_expire = 1'b1;
        step(1);
        wdt_expire = 1'b0;
        step(1);
        chk(status, 5'h02);
        step(7);
        chk({standby, accum, status}, {1'b1, 8'h00, 5'h01});
        wake_req = 1'b1;
        step(1);
        wake_req = 1'b0;
        step(8);
        chk({standby, accum, status}, {1'b0, 8'h77, 5'h00});
        chk(20'(kicks), 20'h00001);
        end_of_test();
    end
endmodule
